//--- gpio_port_pkg.sv
// Purpose: constants shared by the bidirectional port and its irq sense unit
// Assumes: one 25 MHz clock, asynchronous active-low reset
// Notes: pin kinds are set per pin by a parameter vector of the top module
package gpio_port_pkg;
	// ==========================================================
	// register map
	localparam logic [1:0] ADDR_DATA = 2'h0;
	localparam logic [1:0] ADDR_DIR = 2'h1;
	localparam logic [1:0] ADDR_OPT = 2'h2;
	localparam logic [1:0] ADDR_SENSE = 2'h3;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	// ==========================================================
	// pin kinds, two bits per pin in the KIND parameter
	localparam logic [1:0] KIND_STD = 2'h0;
	localparam logic [1:0] KIND_IRQ_PU = 2'h1;
	localparam logic [1:0] KIND_IRQ_FL = 2'h2;
	localparam logic [1:0] KIND_TRUE_OD = 2'h3;
	// ==========================================================
	// sensitivity encoding, two bits per vector
	localparam logic [1:0] SENSE_FALL_LOW = 2'h0;
	localparam logic [1:0] SENSE_RISE = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_BOTH = 2'h3;
	localparam int NUM_VEC = 2;
endpackage

//--- irq_sense.sv
// Purpose: edge/level detection and pending latch for one irq vector
// Assumes: pin levels synchronous to CLK
// Notes: the pending latch is not visible to software
`timescale 1ns/100ps
module irq_sense
(
	input wire logic CLK, // system clock
	input wire logic RST_B, // async reset, active low
	input wire logic [7:0] PIN, // pin levels
	input wire logic [7:0] EN, // pins in interrupt-input mode
	input wire logic [1:0] SENSE, // sensitivity of this vector
	input wire logic SENSE_WR, // sensitivity rewritten
	input wire logic FETCH, // vector fetched by cpu
	output logic PEND // pending request
);
	logic [7:0] prev_r, prev_nxt;
	logic pend_r, pend_nxt;
	logic [7:0] hit;
	logic lvl;

	// ==========================================================
	// detect per pin, then OR into one request
	always_comb
	begin
		prev_nxt = PIN;
		lvl = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			unique case (SENSE)
				gpio_port_pkg::SENSE_FALL_LOW:
				begin
					hit[i] = prev_r[i] & ~PIN[i];
					lvl = lvl | (EN[i] & ~PIN[i]);
				end
				gpio_port_pkg::SENSE_RISE: hit[i] = ~prev_r[i] & PIN[i];
				gpio_port_pkg::SENSE_FALL: hit[i] = prev_r[i] & ~PIN[i];
				gpio_port_pkg::SENSE_BOTH: hit[i] = prev_r[i] ^ PIN[i];
			endcase
		end
		// a sense rewrite flushes stale requests; fetch clears too
		pend_nxt = pend_r;
		if (FETCH || SENSE_WR)
			pend_nxt = 1'b0;
		if (!SENSE_WR && (|(hit & EN) || lvl))
			pend_nxt = 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			prev_r <= 8'hFF;
			pend_r <= 1'b0;
		end
		else
		begin
			prev_r <= prev_nxt;
			pend_r <= pend_nxt;
		end
	end

	assign PEND = pend_r;
endmodule

//--- gpio_port.sv
// Purpose: eight-pin bidirectional port with external interrupt inputs
// Assumes: pin inputs synchronous to CLK; pads resolve output enables
// Notes: OE_B low drives PIN_OUT; pull-up enables go to the pads
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module gpio_port
#(
	parameter logic [15:0] KIND = 16'h0055, // two bits per pin kind
	parameter logic [7:0] VEC_SEL = 8'h00 // vector index of each pin
)
(
	input wire logic CLK, // 25 MHz system clock
	input wire logic RST_B, // async reset, active low
	input wire logic [1:0] ADDR, // register address
	input wire logic [7:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [7:0] RDATA, // read data, cycle after RD
	input wire logic [7:0] PIN_IN, // pin levels
	output logic [7:0] PIN_OUT, // pin drive value
	output logic [7:0] PIN_OE_B, // pin output enable, low drives
	output logic [7:0] PULLUP_EN, // pad pull-up enable
	input wire logic [7:0] ALT_OUT_EN, // peripheral claims pin output
	input wire logic [7:0] ALT_OUT, // peripheral output value
	input wire logic [7:0] ALT_OD, // peripheral wants open-drain
	output logic [7:0] ALT_IN, // value seen by peripheral input
	input wire logic CPU_IMASK, // condition_code interrupt mask set
	input wire logic [1:0] VEC_FETCH, // vector fetch pulses
	output logic [1:0] IRQ_REQ, // interrupt requests
	output logic WAKE // wake from wait or halt
);
	logic [7:0] pin_data_latch_r, pin_data_latch_nxt;
	logic [7:0] dir_r, dir_nxt;
	logic [7:0] opt_r, opt_nxt;
	logic [3:0] edge_sense_config_r, edge_sense_config_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] drv_val, drv_oe_b, pu, irq_en, data_view;
	logic [1:0] pend;

	// decode pin kind from the parameter vector
	function automatic logic [1:0] kind_of(input int i);
		kind_of = KIND[2*i +: 2];
	endfunction

	// ==========================================================
	// register writes; pin_data_latch loads in every mode
	always_comb
	begin
		pin_data_latch_nxt = pin_data_latch_r;
		dir_nxt = dir_r;
		opt_nxt = opt_r;
		edge_sense_config_nxt = edge_sense_config_r;
		if (WR)
		begin
			unique case (ADDR)
				gpio_port_pkg::ADDR_DATA: pin_data_latch_nxt = WDATA;
				gpio_port_pkg::ADDR_DIR: dir_nxt = WDATA;
				gpio_port_pkg::ADDR_OPT: opt_nxt = WDATA;
				gpio_port_pkg::ADDR_SENSE:
					edge_sense_config_nxt = WDATA[3:0];
			endcase
		end
	end

	// ==========================================================
	// pin modes per kind; peripheral output takes priority
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			drv_val[i] = 1'b0;
			drv_oe_b[i] = 1'b1;
			pu[i] = 1'b0;
			irq_en[i] = 1'b0;
			if (ALT_OUT_EN[i])
			begin
				// open-drain request floats the pin on a one
				drv_val[i] = ALT_OUT[i];
				drv_oe_b[i] = ALT_OD[i] & ALT_OUT[i];
			end
			else if (dir_r[i])
			begin
				drv_val[i] = pin_data_latch_r[i];
				if (opt_r[i] && kind_of(i) != gpio_port_pkg::KIND_TRUE_OD)
					drv_oe_b[i] = 1'b0;
				else
					drv_oe_b[i] = pin_data_latch_r[i];
			end
			else if (opt_r[i])
			begin
				// input with option set; true open-drain ignores option
				unique case (kind_of(i))
					gpio_port_pkg::KIND_STD: pu[i] = 1'b1;
					gpio_port_pkg::KIND_IRQ_PU:
					begin
						pu[i] = 1'b1;
						irq_en[i] = 1'b1;
					end
					gpio_port_pkg::KIND_IRQ_FL: irq_en[i] = 1'b1;
					gpio_port_pkg::KIND_TRUE_OD: pu[i] = 1'b0;
				endcase
			end
		end
	end

	// ==========================================================
	// read view: latch in output; in input, alt value if claimed, else pin
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (dir_r[i])
				data_view[i] = pin_data_latch_r[i];
			else if (ALT_OUT_EN[i])
				data_view[i] = ALT_OUT[i];
			else
				data_view[i] = PIN_IN[i];
		end
		ALT_IN = (dir_r & pin_data_latch_r) | (~dir_r & PIN_IN);
		rdata_nxt = 8'h00;
		if (RD)
		begin
			unique case (ADDR)
				gpio_port_pkg::ADDR_DATA: rdata_nxt = data_view;
				gpio_port_pkg::ADDR_DIR: rdata_nxt = dir_r;
				gpio_port_pkg::ADDR_OPT: rdata_nxt = opt_r;
				gpio_port_pkg::ADDR_SENSE:
					rdata_nxt = {4'h0, edge_sense_config_r};
			endcase
		end
	end

	// ==========================================================
	// state registers, all cleared to floating input
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			pin_data_latch_r <= gpio_port_pkg::RESET_VALUE;
			dir_r <= gpio_port_pkg::RESET_VALUE;
			opt_r <= gpio_port_pkg::RESET_VALUE;
			edge_sense_config_r <= 4'h0;
			rdata_r <= 8'h00;
		end
		else
		begin
			pin_data_latch_r <= pin_data_latch_nxt;
			dir_r <= dir_nxt;
			opt_r <= opt_nxt;
			edge_sense_config_r <= edge_sense_config_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// one sense unit per vector, pins grouped by VEC_SEL
	genvar v;
	generate
		for (v = 0; v < gpio_port_pkg::NUM_VEC; v++)
		begin : g_vec
			logic [7:0] grp;
			assign grp = irq_en & ((v == 0) ? ~VEC_SEL : VEC_SEL);
			irq_sense u_sense
			(
				.CLK(CLK),
				.RST_B(RST_B),
				.PIN(PIN_IN),
				.EN(grp),
				.SENSE(edge_sense_config_r[2*v +: 2]),
				.SENSE_WR(WR && ADDR == gpio_port_pkg::ADDR_SENSE),
				.FETCH(VEC_FETCH[v]),
				.PEND(pend[v])
			);
		end
	endgenerate

	// requests gated by cpu mask; wake does not depend on clock gating here
	assign IRQ_REQ = pend & {2{~CPU_IMASK}};
	assign WAKE = |IRQ_REQ;
	assign RDATA = rdata_r;
	assign PIN_OUT = drv_val;
	assign PIN_OE_B = drv_oe_b;
	assign PULLUP_EN = pu;
endmodule

//--- gpio_port_asserts.sv
// Purpose: timing and drive checks at the gpio_port pins
// Assumes: one clock, RST_B asynchronous and active low
// Notes: alternate drive checked on pins 5:0 only
`timescale 1ns/100ps
module gpio_port_asserts
(
	input wire logic CLK, // clock
	input wire logic RST_B, // reset, active low
	input wire logic [1:0] ADDR, // register address
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	input wire logic [7:0] RDATA, // read data
	input wire logic [7:0] PIN_OUT, // drive value
	input wire logic [7:0] PIN_OE_B, // low drives
	input wire logic [7:0] PULLUP_EN, // pull-ups
	input wire logic [7:0] ALT_OUT_EN, // peripheral claim
	input wire logic [7:0] ALT_OUT, // peripheral value
	input wire logic [7:0] ALT_OD, // peripheral open-drain
	input wire logic CPU_IMASK, // cpu mask
	input wire logic [1:0] VEC_FETCH, // vector fetch
	input wire logic [1:0] IRQ_REQ, // requests
	input wire logic WAKE // wake
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// ==========
	// reset and read port
	a_reset_idle: assert property (
		$rose(RST_B) |-> PIN_OE_B == 8'hFF && PULLUP_EN == 8'h00)
		else $error("pins not idle after reset");
	a_rdata_quiet: assert property (
		!$past(RD) |-> RDATA == 8'h00) else $error("read data without read");
	// ==========
	// pin drive
	a_alt_drive: assert property (
		((PIN_OE_B ^ (ALT_OD & ALT_OUT)) & ALT_OUT_EN & 8'h3F) == 8'h00
		&& (~PIN_OE_B & ALT_OUT_EN & (PIN_OUT ^ ALT_OUT) & 8'h3F) == 8'h00)
		else $error("peripheral drive wrong");
	a_od_sink: assert property (
		(~PIN_OE_B & PIN_OUT & ~ALT_OUT_EN & 8'hC0) == 8'h00)
		else $error("open drain pin driven high");
	// ==========
	// interrupt requests
	a_irq_mask: assert property (
		CPU_IMASK |-> IRQ_REQ == 2'h0) else $error("request while masked");
	a_wake_or: assert property (
		WAKE == (|IRQ_REQ)) else $error("wake not tied to requests");
	a_irq_hold: assert property (
		$past(IRQ_REQ[0]) && !$past(VEC_FETCH[0]) && !$past(WR)
		&& !CPU_IMASK |-> IRQ_REQ[0]) else $error("pending request lost");
	a_sense_clear: assert property (
		WR && ADDR == gpio_port_pkg::ADDR_SENSE |=> IRQ_REQ == 2'h0)
		else $error("sense write left request");
endmodule
bind gpio_port gpio_port_asserts u_chk (.CLK, .RST_B, .ADDR, .WR, .RD,
	.RDATA, .PIN_OUT, .PIN_OE_B, .PULLUP_EN, .ALT_OUT_EN, .ALT_OUT,
	.ALT_OD, .CPU_IMASK, .VEC_FETCH, .IRQ_REQ, .WAKE);

//--- pin_world.sv
// Purpose: outside circuit on the eight port pins
// Assumes: pads resolve drive from the active-low enables
// Notes: a released pin follows the outside driver
`timescale 1ns/100ps
module pin_world
(
	input wire logic [7:0] pin_out, // port drive value
	input wire logic [7:0] oe_b, // low drives
	input wire logic [7:0] ext, // outside level
	output logic [7:0] pin_lvl // resolved level
);
	// enabled drive wins; an open-drain one is released to the outside
	assign pin_lvl = (~oe_b & pin_out) | (oe_b & ext);
endmodule

//--- gpio_port_test.sv
// Purpose: self-checking bench for gpio_port
// Assumes: 25 MHz clock, reset held three cycles
// Notes: reads are scored from a queue at the falling edge
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("MISMATCH %0t got %h want %h", $time, (g), (e)); end end
module gpio_port_test;
	logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, imask = 1'b0;
	logic rd_d = 1'b0, wake;
	logic [1:0] addr = 2'h0, fetch = 2'h0, irq;
	logic [7:0] wdata = 8'h00, aen = 8'h00, aout = 8'h00, aod = 8'h00;
	logic [7:0] ext = 8'hFF, d, a, p, rdata, pout, oe_b, pu, ain, lvl;
	logic [7:0] q[$];
	int errors = 0, n_checks = 0;
	gpio_port #(.KIND(16'hF055), .VEC_SEL(8'h0C)) dut (.CLK(clk),
		.RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE_B(oe_b),
		.PULLUP_EN(pu), .ALT_OUT_EN(aen), .ALT_OUT(aout), .ALT_OD(aod),
		.ALT_IN(ain), .CPU_IMASK(imask), .VEC_FETCH(fetch),
		.IRQ_REQ(irq), .WAKE(wake));
	pin_world pw (.pin_out(pout), .oe_b(oe_b), .ext(ext), .pin_lvl(lvl));
	initial
		forever #20 clk = ~clk;
	// read data stands only in the cycle after the strobe
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk)
		if (rd_d)
			`CHK(rdata, q.pop_front())
	task automatic wr_reg(input logic [1:0] ad, input logic [7:0] v);
		@(posedge clk);
		addr <= ad;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] ad, input logic [7:0] e);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic set_ext(input logic [7:0] v);
		@(posedge clk);
		ext <= v;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ==========
	// watchdog, far beyond the hundred or so cycles the run needs
	initial
	begin
		#120000;
		errors++;
		tally_and_finish;
	end
	// ==========
	// main sequence; software never uses read-modify-write
	initial
	begin
		void'($urandom(97524));
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		ext <= $urandom;
		@(negedge clk);
		rd_reg(2'h0, ext);
		for (int i = 1; i < 4; i++)
			rd_reg(i[1:0], 8'h00);
		d = $urandom;
		wr_reg(2'h0, d);
		@(negedge clk);
		`CHK(oe_b, 8'hFF)
		rd_reg(2'h0, ext);
		wr_reg(2'h2, 8'hFF);
		wr_reg(2'h1, 8'hFF);
		@(negedge clk);
		`CHK(oe_b, {d[7:6], 6'h00})
		`CHK(~oe_b & pout, d & 8'h3F)
		rd_reg(2'h0, d);
		wr_reg(2'h2, 8'h00);
		@(negedge clk);
		`CHK(oe_b, d)
		// peripheral on standard pins only, never on interrupt pins
		// option is clear, so pins used both ways stay floating
		a = $urandom;
		@(posedge clk);
		aen <= 8'h30;
		aod <= 8'h10;
		aout <= a;
		@(negedge clk);
		`CHK(ain, d)
		wr_reg(2'h1, 8'h00);
		p = {ext[7:6], a[5], a[4] & ext[4], ext[3:0]};
		@(negedge clk);
		`CHK(ain, p)
		rd_reg(2'h0, {ext[7:6], a[5:4], ext[3:0]});
		wr_reg(2'h2, 8'hFF);
		@(negedge clk);
		// claimed pins 5:4 belong to the peripheral, so their pull-ups stay off
		`CHK(pu, 8'h0F)
		@(posedge clk);
		aen <= 8'h00;
		ext <= 8'hFF;
		// pins 7:4 left floating, as an analog input would need
		wr_reg(2'h2, 8'h0F);
		// every sensitivity code on pin 0, vector 0
		for (int m = 0; m < 4; m++)
		begin
			wr_reg(2'h3, {4'h0, m[1:0], m[1:0]});
			set_ext(8'hFE);
			repeat (3) @(negedge clk);
			`CHK(irq, {1'b0, m != 1})
			set_ext(8'hFF);
			repeat (3) @(negedge clk);
			`CHK(irq, 2'h1)
			@(posedge clk);
			imask <= 1'b1;
			@(negedge clk);
			`CHK(irq, 2'h0)
			@(posedge clk);
			imask <= 1'b0;
			fetch <= 2'h1;
			@(posedge clk);
			fetch <= 2'h0;
			repeat (2) @(negedge clk);
			`CHK(irq, 2'h0)
		end
		// two falling pins share vector 1
		wr_reg(2'h3, 8'h0A);
		set_ext(8'hF3);
		repeat (3) @(negedge clk);
		`CHK(irq, 2'h2)
		wr_reg(2'h3, 8'h0A);
		@(negedge clk);
		`CHK(irq, 2'h0)
		tally_and_finish;
	end
endmodule
